/* design/qd_serial_load.sv */
// How it works
// - Data sampled on falling serial clock, max 50MHz.
// - Low frame select, then 24 bits shifted.
// - Output bit launched on rising serial clock.
// - Output carries readback or daisy-chain data.
// - Strobe pulse copies pending inputs to channels.
// - Strobe works pulsed or held permanently low.
// - Reset pin acts on falling edge, synchronised to system clock.
// - Reset pin low: strobes ignored.
// - Reset loads strap code to input, channel.
// - Power-up code zero or midscale by strap.
// - Gain strap sets common span, x1/x2.
// - Reference pin drives out unless external.
`timescale 1ns/1ps
`include "qd_params.svh"
module qd_serial_load import qd_pkg::*; (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic STB_I,
  input wire logic CYC_I,
  output logic ACK_O,
  input wire logic SCLK_I,
  input wire logic SYNC_N_I,
  input wire logic SERIAL_IN_I,
  output logic SERIAL_OUT_O,
  input wire logic LOAD_STROBE_N_I,
  input wire logic RESET_N_I,
  input wire logic RESET_VALUE_STRAP_I,
  input wire logic GAIN_I,
  output logic SPAN_X2_O,
  output logic REF_OUT_EN_O,
  output logic FRAME_BUSY_O,
  output logic UPDATE_O
);

  function automatic qd_code_t rst_code(input logic strap);
    rst_code = strap ? `QD_MID_CODE : `QD_ZERO_CODE;
  endfunction : rst_code

  function automatic logic [1:0] first_chan(input logic [3:0] sel);
    first_chan = 2'h0;
    for (int i = `QD_CHANNELS - 1; i >= 0; i--) begin
      if (sel[i]) begin
        first_chan = 2'(i);
      end
    end
  endfunction : first_chan

  // Pin synchronisers
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_meta_q;
  logic [NPIN-1:0] pin_sync_q;
  logic [NPIN-1:0] pin_prev_q;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      // Idle pin levels, so no false edge follows reset
      pin_meta_q <= 7'h2C;
      pin_sync_q <= 7'h2C;
      pin_prev_q <= 7'h2C;
    end else begin
      pin_meta_q <= {SCLK_I, SYNC_N_I, SERIAL_IN_I, LOAD_STROBE_N_I,
                     RESET_N_I, RESET_VALUE_STRAP_I, GAIN_I};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  logic sclk_s;
  logic sync_n_s;
  logic serial_in_s;
  logic ldn_s;
  logic rstn_s;
  logic strap_s;
  logic gain_s;
  logic sclk_fall;
  logic sclk_rise;
  logic sync_fall;
  logic sync_rise;
  logic ldn_fall;
  logic rstn_fall;

  assign {sclk_s, sync_n_s, serial_in_s, ldn_s, rstn_s, strap_s, gain_s} = pin_sync_q;
  assign sclk_fall = pin_prev_q[6] && !sclk_s;
  assign sclk_rise = !pin_prev_q[6] && sclk_s;
  assign sync_fall = pin_prev_q[5] && !sync_n_s;
  assign sync_rise = !pin_prev_q[5] && sync_n_s;
  assign ldn_fall = pin_prev_q[3] && !ldn_s;
  assign rstn_fall = pin_prev_q[2] && !rstn_s;

  // Serial receive and transmit
  qd_frame_t in_sr_q;
  qd_frame_t out_sr_q;
  logic [`QD_CNT_W-1:0] bit_cnt_q;
  logic push_v_q;
  qd_frame_t push_data_q;
  logic rb_pend_q;
  qd_code_t rb_data_q;
  logic rb_set;
  logic daisy_q;
  logic buf_in_ready;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      in_sr_q <= 24'h000000;
      bit_cnt_q <= 5'h00;
      push_v_q <= 1'b0;
      push_data_q <= 24'h000000;
    end else begin
      push_v_q <= 1'b0;
      if (sync_fall) begin
        bit_cnt_q <= 5'h00;
      end else if (sclk_fall && !sync_n_s && bit_cnt_q < 5'(`QD_FRAME_BITS)) begin
        in_sr_q <= {in_sr_q[22:0], serial_in_s};
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      if (sync_rise && bit_cnt_q == 5'(`QD_FRAME_BITS)) begin
        push_v_q <= 1'b1;
        push_data_q <= in_sr_q;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      out_sr_q <= 24'h000000;
      rb_pend_q <= 1'b0;
      SERIAL_OUT_O <= 1'b0;
    end else begin
      if (rb_set) begin
        rb_pend_q <= 1'b1;
      end else if (sync_fall) begin
        rb_pend_q <= 1'b0;
      end
      if (sync_fall) begin
        out_sr_q <= rb_pend_q ? {8'h00, rb_data_q} : 24'h000000;
      end else if (sclk_rise && !sync_n_s) begin
        SERIAL_OUT_O <= daisy_q ? in_sr_q[23] : out_sr_q[23];
        out_sr_q <= {out_sr_q[22:0], 1'b0};
      end
    end
  end

  // Frame buffer between receiver and executor
  logic ctrl_hold_q;
  logic buf_out_valid;
  qd_frame_t buf_out_data;
  logic exec;

  qd_frame_buf #(
    .WIDTH(`QD_FRAME_BITS),
    .DEPTH(2)
  ) u_buf (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .in_valid_i(push_v_q),
    .in_ready_o(buf_in_ready),
    .in_data_i(push_data_q),
    .out_valid_o(buf_out_valid),
    .out_ready_i(!ctrl_hold_q),
    .out_data_o(buf_out_data)
  );

  assign exec = buf_out_valid && !ctrl_hold_q;

  logic [3:0] f_cmd;
  logic [3:0] f_addr;
  qd_code_t f_data;

  assign f_cmd = buf_out_data[`QD_CMD_MSB:`QD_CMD_LSB];
  assign f_addr = buf_out_data[`QD_ADDR_MSB:`QD_ADDR_LSB];
  assign f_data = buf_out_data[`QD_DATA_MSB:0];

  // Power-up sequencing
  qd_state_t state_q;
  logic [1:0] init_cnt_q;
  logic init_load;

  assign init_load = (state_q == QD_ST_POWERUP) && init_cnt_q == `QD_INIT_WAIT && rstn_s;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_q <= QD_ST_POWERUP;
      init_cnt_q <= 2'h0;
    end else begin
      case (state_q)
        QD_ST_POWERUP: begin
          if (init_cnt_q != `QD_INIT_WAIT) begin
            init_cnt_q <= init_cnt_q + 2'h1;
          end else if (rstn_s) begin
            state_q <= QD_ST_RUN;
          end
        end
        QD_ST_RUN: begin
          state_q <= QD_ST_RUN;
        end
        default: begin
          state_q <= QD_ST_POWERUP;
        end
      endcase
    end
  end

  // Input and channel registers
  qd_code_t input_q [`QD_CHANNELS];
  qd_code_t chan_q [`QD_CHANNELS];
  logic [3:0] pend_q;
  logic ext_ref_q;
  logic running;
  logic strobe_pulse;
  logic strobe_held;

  assign running = (state_q == QD_ST_RUN);
  assign strobe_pulse = running && ldn_fall && rstn_s;
  assign strobe_held = running && !ldn_s && rstn_s;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      for (int i = 0; i < `QD_CHANNELS; i++) begin
        input_q[i] <= `QD_ZERO_CODE;
        chan_q[i] <= `QD_ZERO_CODE;
      end
      pend_q <= 4'h0;
      UPDATE_O <= 1'b0;
    end else if (init_load || (running && rstn_fall)) begin
      for (int i = 0; i < `QD_CHANNELS; i++) begin
        input_q[i] <= rst_code(strap_s);
        chan_q[i] <= rst_code(strap_s);
      end
      pend_q <= 4'h0;
      UPDATE_O <= 1'b1;
    end else begin
      UPDATE_O <= 1'b0;
      for (int i = 0; i < `QD_CHANNELS; i++) begin
        if (strobe_pulse && pend_q[i]) begin
          chan_q[i] <= input_q[i];
          pend_q[i] <= 1'b0;
          UPDATE_O <= 1'b1;
        end
        if (exec && running && f_addr[i]) begin
          if (f_cmd == `QD_CMD_WR_INPUT) begin
            input_q[i] <= f_data;
            if (strobe_held) begin
              chan_q[i] <= f_data;
              pend_q[i] <= 1'b0;
              UPDATE_O <= 1'b1;
            end else begin
              pend_q[i] <= 1'b1;
            end
          end else if (f_cmd == `QD_CMD_WR_UPD) begin
            input_q[i] <= f_data;
            chan_q[i] <= f_data;
            pend_q[i] <= 1'b0;
            UPDATE_O <= 1'b1;
          end else if (f_cmd == `QD_CMD_UPD_CHAN) begin
            chan_q[i] <= input_q[i];
            pend_q[i] <= 1'b0;
            UPDATE_O <= 1'b1;
          end
        end
      end
    end
  end

  // Mode bits and readback capture
  assign rb_set = exec && running && f_cmd == `QD_CMD_READBACK;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ext_ref_q <= 1'b0;
      daisy_q <= 1'b0;
      rb_data_q <= `QD_ZERO_CODE;
    end else if (exec && running) begin
      if (f_cmd == `QD_CMD_REF_SEL) begin
        ext_ref_q <= f_data[0];
      end
      if (f_cmd == `QD_CMD_DAISY) begin
        daisy_q <= f_data[0];
      end
      if (f_cmd == `QD_CMD_READBACK) begin
        rb_data_q <= chan_q[first_chan(f_addr)];
      end
    end
  end

  // Span, reference enable and busy outputs
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      SPAN_X2_O <= 1'b0;
      REF_OUT_EN_O <= 1'b1;
      FRAME_BUSY_O <= 1'b0;
    end else begin
      SPAN_X2_O <= gain_s;
      REF_OUT_EN_O <= !ext_ref_q;
      FRAME_BUSY_O <= !buf_in_ready;
    end
  end

  // Wishbone slave
  logic overrun_q;
  logic wb_req;
  logic wb_wr;
  logic [31:0] rd_d;

  assign wb_req = CYC_I && STB_I && !ACK_O;
  assign wb_wr = wb_req && WE_I && SEL_I[0];

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ctrl_hold_q <= `QD_CTRL_RESET;
    end else if (wb_wr && ADR_I == `QD_OFS_CTRL) begin
      ctrl_hold_q <= DAT_I[`QD_CTRL_HOLD];
    end
  end

  // Lost frame flag, set beats clear
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      overrun_q <= 1'b0;
    end else if (push_v_q && !buf_in_ready) begin
      overrun_q <= 1'b1;
    end else if (wb_wr && ADR_I == `QD_OFS_STATUS && DAT_I[`QD_ST_OVERRUN]) begin
      overrun_q <= 1'b0;
    end
  end

  always_comb begin
    rd_d = 32'h00000000;
    if (ADR_I == `QD_OFS_CTRL) begin
      rd_d[`QD_CTRL_HOLD] = ctrl_hold_q;
    end else if (ADR_I == `QD_OFS_STATUS) begin
      rd_d[`QD_ST_OVERRUN] = overrun_q;
      rd_d[`QD_ST_FULL] = !buf_in_ready;
      rd_d[`QD_ST_DAISY] = daisy_q;
      rd_d[`QD_ST_EXT_REF] = ext_ref_q;
      rd_d[`QD_ST_SPAN_X2] = SPAN_X2_O;
      rd_d[`QD_ST_RST_LOW] = !rstn_s;
      rd_d[`QD_ST_INIT] = running;
    end else if (ADR_I[7:4] == `QD_OFS_CHAN0 >> 4 && ADR_I[1:0] == 2'h0) begin
      rd_d[15:0] = chan_q[ADR_I[3:2]];
    end else if (ADR_I[7:4] == `QD_OFS_INPUT0 >> 4 && ADR_I[1:0] == 2'h0) begin
      rd_d[15:0] = input_q[ADR_I[3:2]];
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h00000000;
    end else begin
      ACK_O <= wb_req;
      DAT_O <= (wb_req && !WE_I) ? rd_d : 32'h00000000;
    end
  end

endmodule : qd_serial_load

/* design/qd_params.svh */
`ifndef QD_PARAMS_SVH
`define QD_PARAMS_SVH

// Serial frame layout
`define QD_FRAME_BITS 24
`define QD_CNT_W 5
`define QD_CMD_MSB 23
`define QD_CMD_LSB 20
`define QD_ADDR_MSB 19
`define QD_ADDR_LSB 16
`define QD_DATA_MSB 15
`define QD_CHANNELS 4

// Frame commands
`define QD_CMD_WR_INPUT 4'h1
`define QD_CMD_UPD_CHAN 4'h2
`define QD_CMD_WR_UPD 4'h3
`define QD_CMD_REF_SEL 4'h7
`define QD_CMD_READBACK 4'h9
`define QD_CMD_DAISY 4'hF

// Reset codes
`define QD_ZERO_CODE 16'h0000
`define QD_MID_CODE 16'h8000

// Wishbone byte offsets
`define QD_OFS_CTRL 8'h00
`define QD_OFS_STATUS 8'h04
`define QD_OFS_CHAN0 8'h10
`define QD_OFS_INPUT0 8'h20

// Field positions
`define QD_CTRL_HOLD 0
`define QD_ST_OVERRUN 0
`define QD_ST_FULL 1
`define QD_ST_DAISY 2
`define QD_ST_EXT_REF 3
`define QD_ST_SPAN_X2 4
`define QD_ST_RST_LOW 5
`define QD_ST_INIT 6

// Reset value and power-up wait count
`define QD_CTRL_RESET 1'b0
`define QD_INIT_WAIT 2'h3

`endif

/* design/qd_pkg.sv */
package qd_pkg;

  typedef enum logic [1:0] {
    QD_ST_POWERUP = 2'b01,
    QD_ST_RUN = 2'b10
  } qd_state_t;

  typedef logic [15:0] qd_code_t;
  typedef logic [23:0] qd_frame_t;

endpackage : qd_pkg

/* design/qd_frame_buf.sv */
`timescale 1ns/1ps
module qd_frame_buf #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule : qd_frame_buf

/* tb/qd_serial_load_properties.sv */
`timescale 1ns/1ps
module qd_serial_load_properties (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O,
  input wire logic [31:0] DAT_O,
  input wire logic SCLK_I,
  input wire logic SYNC_N_I,
  input wire logic SERIAL_OUT_O,
  input wire logic RESET_N_I,
  input wire logic GAIN_I,
  input wire logic SPAN_X2_O,
  input wire logic REF_OUT_EN_O,
  input wire logic UPDATE_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  AST_ACK_NEXT: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack late");
  AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
  AST_DAT_IDLE: assert property (!ACK_O |-> DAT_O == 32'h0) else $error("read data outside ack");
  AST_SDO_RISE: assert property ($changed(SERIAL_OUT_O) |-> $past(SCLK_I, 2)) else $error("sdo off edge");
  AST_SDO_FRAME: assert property ($changed(SERIAL_OUT_O) |-> !$past(SYNC_N_I, 2))
    else $error("sdo out of frame");
  AST_SPAN: assert property ($rose(GAIN_I) |-> ##[1:5] SPAN_X2_O) else $error("span not set");
  AST_REF_BOOT: assert property ($fell(SYS_RST_I) |-> REF_OUT_EN_O) else $error("ref not driven");
  AST_BOOT_LOAD: assert property ($fell(SYS_RST_I) && RESET_N_I |-> ##[2:12] UPDATE_O)
    else $error("no boot load");
  AST_RSTN_LOAD: assert property ($fell(RESET_N_I) |-> ##[1:8] UPDATE_O)
    else $error("no pin reset load");
  AST_RSTN_MUTE: assert property (!RESET_N_I [*8] |-> !UPDATE_O) else $error("update in reset");
endmodule : qd_serial_load_properties

bind qd_serial_load qd_serial_load_properties u_props (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CYC_I(CYC_I),
  .STB_I(STB_I), .ACK_O(ACK_O), .DAT_O(DAT_O), .SCLK_I(SCLK_I), .SYNC_N_I(SYNC_N_I),
  .SERIAL_OUT_O(SERIAL_OUT_O), .RESET_N_I(RESET_N_I), .GAIN_I(GAIN_I), .SPAN_X2_O(SPAN_X2_O),
  .REF_OUT_EN_O(REF_OUT_EN_O), .UPDATE_O(UPDATE_O));

/* tb/qd_host_model.sv */
`timescale 1ns/1ps
module qd_host_model (
  input wire logic clk_i,
  input wire logic serial_out_i,
  output logic sclk_o,
  output logic sync_n_o,
  output logic sdi_o
);
  logic [23:0] cap = 24'h0;

  initial begin
    sclk_o = 1'b0;
    sync_n_o = 1'b1;
    sdi_o = 1'b0;
  end

  // Clock stands low between frames
  task automatic send(input logic [23:0] f, input int n);
    repeat (2) @(posedge clk_i);
    sync_n_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      sdi_o <= f[23-i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
      cap <= {cap[22:0], serial_out_i};
    end
    repeat (4) @(posedge clk_i);
    sync_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (10) @(posedge clk_i);
  endtask : send
endmodule : qd_host_model

/* tb/qd_serial_load_tb.sv */
`timescale 1ns/1ps
`include "qd_params.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module qd_serial_load_tb import qd_pkg::*; ;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, stb = 1'b0, cyc = 1'b0;
  logic strobe_n = 1'b1, strap = 1'b0, gain = 1'b0;
  logic reset_n = 1'b1;
  logic ack, sclk, sync_n, sdi, serial_out, span, ref_en, busy, upd;
  logic [7:0] adr = 8'h0;
  logic [31:0] dw = 32'h0, dr, r;
  int errors = 0, n_compared = 0;

  always #25 clk = ~clk;

  qd_serial_load DUT (.CLK_I(clk), .SYS_RST_I(rst), .ADR_I(adr), .DAT_I(dw), .DAT_O(dr), .WE_I(we),
    .SEL_I(4'hF), .STB_I(stb), .CYC_I(cyc), .ACK_O(ack), .SCLK_I(sclk), .SYNC_N_I(sync_n),
    .SERIAL_IN_I(sdi), .SERIAL_OUT_O(serial_out), .LOAD_STROBE_N_I(strobe_n), .RESET_N_I(reset_n),
    .RESET_VALUE_STRAP_I(strap), .GAIN_I(gain), .SPAN_X2_O(span), .REF_OUT_EN_O(ref_en),
    .FRAME_BUSY_O(busy), .UPDATE_O(upd));
  qd_host_model host (.clk_i(clk), .serial_out_i(serial_out), .sclk_o(sclk), .sync_n_o(sync_n), .sdi_o(sdi));

  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    r = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      errors++;
      end_sim();
    end
    @(posedge clk);
  endtask : wb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(r, e)
  endtask : rdc

  task automatic wait_upd;
    int k;
    k = 0;
    while (upd !== 1'b1 && k < 40) begin
      @(posedge clk);
      k++;
    end
    `CHK(upd, 1'b1)
  endtask : wait_upd

  task automatic wait_run;
    r = 32'h0;
    for (int k = 0; k < 20 && r[6] !== 1'b1; k++) wb(1'b0, `QD_OFS_STATUS, 32'h0);
    `CHK(r[6], 1'b1)
  endtask : wait_run

  task automatic t_boot;
    wait_run();
    for (int i = 0; i < 4; i++) begin
      rdc(`QD_OFS_CHAN0 + 8'(4 * i), 32'h0);
      rdc(`QD_OFS_INPUT0 + 8'(4 * i), 32'h0);
    end
    `CHK(ref_en, 1'b1)
    rdc(`QD_OFS_STATUS, 32'h40);
    gain <= 1'b1;
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'h0);
    rdc(`QD_OFS_STATUS, 32'h50);
    `CHK(span, 1'b1)
    $display("boot done");
  endtask : t_boot

  task automatic t_strobe;
    host.send({`QD_CMD_WR_INPUT, 4'h3, 16'h1234}, 24);
    rdc(`QD_OFS_INPUT0 + 8'h4, 32'h1234);
    rdc(`QD_OFS_CHAN0, 32'h0);
    strobe_n <= 1'b0;
    wait_upd();
    strobe_n <= 1'b1;
    rdc(`QD_OFS_CHAN0, 32'h1234);
    rdc(`QD_OFS_CHAN0 + 8'h4, 32'h1234);
    rdc(`QD_OFS_CHAN0 + 8'h8, 32'h0);
    strobe_n <= 1'b0;
    host.send({`QD_CMD_WR_INPUT, 4'h4, 16'hA5A5}, 24);
    rdc(`QD_OFS_CHAN0 + 8'h8, 32'hA5A5);
    strobe_n <= 1'b1;
    $display("strobe done");
  endtask : t_strobe

  task automatic t_cmds;
    host.send({`QD_CMD_WR_UPD, 4'h8, 16'hBEEF}, 23);
    rdc(`QD_OFS_CHAN0 + 8'hC, 32'h0);
    host.send({`QD_CMD_WR_UPD, 4'h8, 16'h0F0F}, 24);
    rdc(`QD_OFS_CHAN0 + 8'hC, 32'h0F0F);
    host.send({`QD_CMD_WR_INPUT, 4'h1, 16'h7777}, 24);
    host.send({`QD_CMD_UPD_CHAN, 4'h1, 16'h0}, 24);
    rdc(`QD_OFS_CHAN0, 32'h7777);
    $display("cmds done");
  endtask : t_cmds

  task automatic t_buf;
    wb(1'b1, `QD_OFS_CTRL, 32'h1);
    host.send({`QD_CMD_WR_UPD, 4'h1, 16'h1111}, 24);
    host.send({`QD_CMD_WR_UPD, 4'h1, 16'h2222}, 24);
    `CHK(busy, 1'b1)
    host.send({`QD_CMD_WR_UPD, 4'h1, 16'h3333}, 24);
    rdc(`QD_OFS_STATUS, 32'h53);
    wb(1'b1, `QD_OFS_STATUS, 32'h1);
    rdc(`QD_OFS_STATUS, 32'h52);
    wb(1'b1, `QD_OFS_CTRL, 32'h0);
    // Let both held frames drain
    repeat (8) @(posedge clk);
    `CHK(busy, 1'b0)
    rdc(`QD_OFS_CHAN0, 32'h2222);
    $display("buffer done");
  endtask : t_buf

  task automatic t_link;
    host.send({`QD_CMD_READBACK, 4'h2, 16'h0}, 24);
    host.send({`QD_CMD_READBACK, 4'h2, 16'h0}, 24);
    `CHK(host.cap, 24'h001234)
    strap <= 1'b1;
    host.send({`QD_CMD_REF_SEL, 4'h0, 16'h0001}, 24);
    `CHK(ref_en, 1'b0)
    reset_n <= 1'b0;
    wait_upd();
    host.send({`QD_CMD_WR_INPUT, 4'h2, 16'h5555}, 24);
    strobe_n <= 1'b0;
    rdc(`QD_OFS_INPUT0 + 8'h4, 32'h5555);
    rdc(`QD_OFS_INPUT0 + 8'hC, 32'h8000);
    rdc(`QD_OFS_CHAN0 + 8'h4, 32'h8000);
    strobe_n <= 1'b1;
    reset_n <= 1'b1;
    host.send({`QD_CMD_DAISY, 4'h0, 16'h0001}, 24);
    host.send(24'hC3A55A, 24);
    `CHK(host.cap, ({`QD_CMD_DAISY, 4'h0, 16'h0001}))
    $display("link done");
  endtask : t_link

  task automatic t_reboot;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_run();
    rdc(`QD_OFS_CHAN0 + 8'h8, 32'h8000);
    rdc(`QD_OFS_INPUT0 + 8'h4, 32'h8000);
    `CHK(ref_en, 1'b1)
    $display("reboot done");
  endtask : t_reboot

  initial begin
    r = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_boot();
    t_strobe();
    t_cmds();
    t_buf();
    t_link();
    t_reboot();
    end_sim();
  end
endmodule : qd_serial_load_tb
